// ### verilog/dpf_ctrl.sv
`timescale 1ns/1ps
`include "dpf_consts.svh"
module dpf_ctrl import dpf_pkg::*; #(
   parameter int unsigned ACT_COLS = 1600,
   parameter int unsigned ACT_ROWS = 1200,
   parameter int unsigned ROW_PIX = 1800,
   parameter int unsigned VBLANK_ROWS = 32
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic [9:0] pix_data_o,
   output logic line_active_o,
   output logic frame_active_o,
   output logic flash_strobe_o,
   output logic irq_o
);
   ////////////////////////////////////////////////////////////////////
   // bus slave and registers
   dpf_reg16_t rm_reg;
   dpf_reg16_t sc_reg;
   dpf_reg16_t fc_reg;
   logic ctx_reg;
   logic trig_reg;
   logic [`DPF_NUM_EVT-1:0] irq_st_reg;
   logic [`DPF_NUM_EVT-1:0] irq_st_next;
   logic [`DPF_NUM_EVT-1:0] irq_en_reg;
   logic [`DPF_NUM_EVT-1:0] evt;
   logic [9:0] idx;
   logic req;
   logic wr;
   logic [31:0] rd_next;

   assign idx = wb_adr_i[11:2];
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

   function automatic dpf_reg16_t merge(input dpf_reg16_t old,
                                        input logic [31:0] d,
                                        input logic [3:0] sel);
      dpf_reg16_t r;
      r = old;
      if (sel[0]) begin
         r[7:0] = d[7:0];
      end
      if (sel[1]) begin
         r[15:8] = d[15:8];
      end
      return r;
   endfunction

   // ack one cycle after the request; a write lands on the ack edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= req ? rd_next : 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rm_reg <= `DPF_RST_READ_MODE_A;
         sc_reg <= `DPF_RST_SHOW_CTRL;
         fc_reg <= `DPF_RST_FLASH_CTRL;
         ctx_reg <= 1'b0;
         irq_en_reg <= '0;
      end else if (wr) begin
         if (idx == `DPF_IDX_READ_MODE_A) begin
            rm_reg <= merge(rm_reg, wb_dat_i, wb_sel_i);
         end
         if (idx == `DPF_IDX_SHOW_CTRL) begin
            // reserved bit kept as written
            sc_reg <= merge(sc_reg, wb_dat_i, wb_sel_i);
         end
         if (idx == `DPF_IDX_FLASH_CTRL) begin
            fc_reg <= merge(fc_reg, wb_dat_i, wb_sel_i) & `DPF_FC_WR_MASK;
         end
         if (idx == `DPF_IDX_CTX_SEL && wb_sel_i[0]) begin
            ctx_reg <= wb_dat_i[`DPF_CTX_SEL_BIT];
         end
         if (idx == `DPF_IDX_IRQ_ENABLE && wb_sel_i[0]) begin
            irq_en_reg <= wb_dat_i[`DPF_NUM_EVT-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // derived configuration
   logic ctx_a;
   logic binning;
   logic skip_on;
   logic [10:0] act_rows;
   logic [5:0] ncols;
   logic [5:0] first_col;
   logic [5:0] read_cols;
   logic [5:0] lead;
   logic show_rows;
   logic [3:0] ndark_rows;
   logic [10:0] vb_rows;

   assign ctx_a = ~ctx_reg;
   assign binning = ctx_a & rm_reg[`DPF_RM_BIN];
   assign skip_on = ctx_a & rm_reg[`DPF_RM_RSKIP_EN];

   always_comb begin
      act_rows = 11'(ACT_ROWS);
      if (skip_on) begin
         // 00 halves, each step halves again
         act_rows = 11'(ACT_ROWS >>
            (int'(rm_reg[`DPF_RM_RSKIP_HI:`DPF_RM_RSKIP_LO]) + 1));
      end
   end

   always_comb begin
      if (binning) begin
         ncols = `DPF_DARK_COLS_ALL;
         first_col = `DPF_DARK_COL_BIN_FIRST;
      end else if (sc_reg[`DPF_SC_NCOL]) begin
         ncols = `DPF_DARK_COLS_WIDE;
         first_col = `DPF_DARK_COL_FIRST;
      end else begin
         ncols = `DPF_DARK_COLS_NARROW;
         first_col = `DPF_DARK_COL_FIRST;
      end
   end

   // read count only shows in the dark status register, row length is fixed
   assign read_cols = sc_reg[`DPF_SC_READ_COL] ? ncols : 6'h00;
   assign lead = sc_reg[`DPF_SC_SHOW_COL] ?
                 ncols + `DPF_DARK_GAP : 6'h00;
   assign show_rows = sc_reg[`DPF_SC_SHOW_ROW];
   assign ndark_rows = {1'b0, sc_reg[`DPF_SC_NROW_HI:`DPF_SC_NROW_LO]}
                       + 4'h1;
   // dark rows come out of vertical blanking, frame rate unchanged
   assign vb_rows = 11'(VBLANK_ROWS) -
                    (show_rows ? 11'(ndark_rows) : 11'h000);

   ////////////////////////////////////////////////////////////////////
   // pixel rate and line timing
   logic [1:0] div_reg;
   logic pix_en;
   logic eol;
   logic hact;
   logic dark_col;
   logic [10:0] col;

   assign pix_en = (div_reg == `DPF_PIX_DIV - 2'h1);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_reg <= 2'h0;
      end else begin
         div_reg <= pix_en ? 2'h0 : div_reg + 2'h1;
      end
   end

   dpf_line_timer #(
      .ACT_COLS(ACT_COLS),
      .ROW_PIX(ROW_PIX)
   ) u_line (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pix_en_i(pix_en),
      .lead_i(lead),
      .ncols_i(ncols),
      .eol_o(eol),
      .hact_o(hact),
      .dark_o(dark_col),
      .col_o(col)
   );

   ////////////////////////////////////////////////////////////////////
   // row sequencer; >= ends survive a smaller size set mid-frame
   dpf_row_state_t state_reg;
   logic [10:0] row_reg;
   logic frame_start;
   logic vb_end;
   assign frame_start = eol && state_reg == DPF_ST_ACTIVE &&
                        row_reg >= act_rows - 11'h001;
   assign vb_end = eol && state_reg == DPF_ST_VBLANK &&
                   row_reg >= vb_rows - 11'h001;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= DPF_ST_VBLANK;
         row_reg <= 11'h000;
      end else if (eol) begin
         row_reg <= row_reg + 11'h001;
         unique case (state_reg)
            DPF_ST_VBLANK: begin
               if (vb_end) begin
                  row_reg <= 11'h000;
                  state_reg <= show_rows ? DPF_ST_DARK : DPF_ST_ACTIVE;
               end
            end
            DPF_ST_DARK: begin
               if (row_reg >= 11'(ndark_rows) - 11'h001) begin
                  row_reg <= 11'h000;
                  state_reg <= DPF_ST_ACTIVE;
               end
            end
            DPF_ST_ACTIVE: begin
               if (frame_start) begin
                  row_reg <= 11'h000;
                  state_reg <= DPF_ST_VBLANK;
               end
            end
         endcase
      end
   end

   // pixel stream, all outputs registered
   logic [3:0] dark_row_addr;
   logic [9:0] data_next;

   // software keeps start plus count inside the eight rows
   assign dark_row_addr = `DPF_DARK_ROW_OFS +
      {1'b0, sc_reg[`DPF_SC_RSTART_HI:`DPF_SC_RSTART_LO]} +
      row_reg[3:0];

   always_comb begin
      data_next = 10'h000;
      if (dark_col) begin
         data_next = {4'h0, first_col + col[5:0]};
      end else if (col < 11'(lead)) begin
         data_next = 10'h000;
      end else if (state_reg == DPF_ST_DARK) begin
         data_next = {6'h00, dark_row_addr};
      end else begin
         data_next = col[9:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         frame_active_o <= 1'b0;
         line_active_o <= 1'b0;
         pix_data_o <= 10'h000;
      end else begin
         frame_active_o <= (state_reg != DPF_ST_VBLANK);
         line_active_o <= (state_reg != DPF_ST_VBLANK) & hact;
         pix_data_o <= ((state_reg != DPF_ST_VBLANK) & hact) ?
                       data_next : 10'h000;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // xenon flash
   logic xenon_en;
   logic [1:0] dly_reg;
   logic [1:0] dly_set;
   logic fire;
   logic strobe;
   assign xenon_en = fc_reg[`DPF_FC_XENON];
   assign dly_set = fc_reg[`DPF_FC_DELAY_HI:`DPF_FC_DELAY_LO];
   // fires only at the start of vertical blanking
   assign fire = xenon_en & frame_start & (dly_reg == dly_set);
   // counts frames up from enable: a delay written with the enable holds
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dly_reg <= 2'h0;
      end else if (!xenon_en) begin
         dly_reg <= 2'h0;
      end else if (frame_start && dly_reg != dly_set) begin
         dly_reg <= dly_reg + 2'h1;
      end
   end
   dpf_flash_timer u_flash (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pix_en_i(pix_en),
      .start_i(fire),
      .stop_i(vb_end | ~xenon_en),
      .count_i(fc_reg[`DPF_FC_COUNT_HI:`DPF_FC_COUNT_LO]),
      .strobe_o(strobe)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flash_strobe_o <= 1'b0;
      end else begin
         flash_strobe_o <= strobe;
      end
   end

   // set wins over the frame boundary clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trig_reg <= 1'b0;
      end else if (flash_strobe_o) begin
         trig_reg <= 1'b1;
      end else if (frame_start) begin
         trig_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // interrupts and read mux
   assign evt[`DPF_EVT_FRAME] = frame_start;
   assign evt[`DPF_EVT_FLASH_ON] = strobe & ~flash_strobe_o;
   assign evt[`DPF_EVT_FLASH_OFF] = ~strobe & flash_strobe_o;

   always_comb begin
      irq_st_next = irq_st_reg;
      if (wr && idx == `DPF_IDX_IRQ_CLEAR && wb_sel_i[0]) begin
         irq_st_next = irq_st_reg & ~wb_dat_i[`DPF_NUM_EVT-1:0];
      end
      irq_st_next = irq_st_next | evt;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_st_reg <= '0;
         irq_o <= 1'b0;
      end else begin
         irq_st_reg <= irq_st_next;
         irq_o <= |(irq_st_next & irq_en_reg);
      end
   end

   always_comb begin
      rd_next = 32'h0000_0000;
      unique case (idx)
         `DPF_IDX_READ_MODE_A: rd_next[15:0] = rm_reg;
         `DPF_IDX_SHOW_CTRL: rd_next[15:0] = sc_reg;
         `DPF_IDX_FLASH_CTRL: begin
            rd_next[15:0] = fc_reg;
            rd_next[`DPF_FC_LEVEL] = flash_strobe_o;
            rd_next[`DPF_FC_TRIG] = trig_reg;
         end
         `DPF_IDX_CTX_SEL: rd_next[`DPF_CTX_SEL_BIT] = ctx_reg;
         `DPF_IDX_IRQ_STATUS: rd_next[`DPF_NUM_EVT-1:0] = irq_st_reg;
         `DPF_IDX_IRQ_ENABLE: rd_next[`DPF_NUM_EVT-1:0] = irq_en_reg;
         `DPF_IDX_DARK_STATUS: rd_next[13:0] = {2'h0, lead, 6'h00} |
                                               {8'h00, read_cols};
         default: rd_next = 32'h0000_0000;
      endcase
   end
endmodule

// ### verilog/dpf_consts.svh
`ifndef DPF_CONSTS_SVH
`define DPF_CONSTS_SVH
// register indices, byte address is index times four
`define DPF_IDX_READ_MODE_A 10'h021
`define DPF_IDX_SHOW_CTRL 10'h022
`define DPF_IDX_FLASH_CTRL 10'h023
`define DPF_IDX_IRQ_STATUS 10'h030
`define DPF_IDX_IRQ_CLEAR 10'h031
`define DPF_IDX_IRQ_ENABLE 10'h032
`define DPF_IDX_DARK_STATUS 10'h033
`define DPF_IDX_CTX_SEL 10'h0F2
// reset values, flash control write mask
`define DPF_RST_READ_MODE_A 16'h8490
`define DPF_RST_SHOW_CTRL 16'h0107
`define DPF_RST_FLASH_CTRL 16'h0008
`define DPF_FC_WR_MASK 16'h38FF
// read mode context a fields, context select bit
`define DPF_RM_BIN 15
`define DPF_RM_RSKIP_EN 4
`define DPF_RM_RSKIP_HI 3
`define DPF_RM_RSKIP_LO 2
`define DPF_CTX_SEL_BIT 3
// dark pixel show control fields
`define DPF_SC_NCOL 10
`define DPF_SC_SHOW_COL 9
`define DPF_SC_READ_COL 8
`define DPF_SC_SHOW_ROW 7
`define DPF_SC_RSTART_HI 6
`define DPF_SC_RSTART_LO 4
`define DPF_SC_NROW_HI 2
`define DPF_SC_NROW_LO 0
// flash strobe control fields
`define DPF_FC_LEVEL 15
`define DPF_FC_TRIG 14
`define DPF_FC_XENON 13
`define DPF_FC_DELAY_HI 12
`define DPF_FC_DELAY_LO 11
`define DPF_FC_COUNT_HI 7
`define DPF_FC_COUNT_LO 0
// dark pixel geometry
`define DPF_DARK_COLS_ALL 6'h28
`define DPF_DARK_COLS_WIDE 6'h24
`define DPF_DARK_COLS_NARROW 6'h14
`define DPF_DARK_COL_FIRST 6'h04
`define DPF_DARK_COL_BIN_FIRST 6'h00
`define DPF_DARK_GAP 6'h02
`define DPF_DARK_ROW_OFS 4'h4
// timing
`define DPF_XENON_UNIT_BITS 10
`define DPF_PIX_DIV 2'h2
// interrupt events
`define DPF_NUM_EVT 3
`define DPF_EVT_FRAME 0
`define DPF_EVT_FLASH_ON 1
`define DPF_EVT_FLASH_OFF 2
`endif

// ### verilog/dpf_pkg.sv
package dpf_pkg;
   typedef enum logic [1:0] {
      DPF_ST_VBLANK,
      DPF_ST_DARK,
      DPF_ST_ACTIVE
   } dpf_row_state_t;
   typedef logic [15:0] dpf_reg16_t;
endpackage

// ### verilog/dpf_line_timer.sv
`timescale 1ns/1ps
`include "dpf_consts.svh"
module dpf_line_timer import dpf_pkg::*; #(
   parameter int unsigned ACT_COLS = 1600,
   parameter int unsigned ROW_PIX = 1800
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic pix_en_i,
   input wire logic [5:0] lead_i,
   input wire logic [5:0] ncols_i,
   output logic eol_o,
   output logic hact_o,
   output logic dark_o,
   output logic [10:0] col_o
);
   logic [10:0] col_reg;
   logic last;

   // row length is fixed, dark columns eat into blanking only
   assign last = (col_reg == 11'(ROW_PIX - 1));
   assign eol_o = pix_en_i & last;
   assign col_o = col_reg;
   assign hact_o = (col_reg < (11'(lead_i) + 11'(ACT_COLS)));
   assign dark_o = (lead_i != 6'h00) & (col_reg < 11'(ncols_i));

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         col_reg <= 11'h000;
      end else if (pix_en_i) begin
         col_reg <= last ? 11'h000 : col_reg + 11'h001;
      end
   end
endmodule

// ### verilog/dpf_flash_timer.sv
`timescale 1ns/1ps
`include "dpf_consts.svh"
module dpf_flash_timer (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic pix_en_i,
   input wire logic start_i,
   input wire logic stop_i,
   input wire logic [7:0] count_i,
   output logic strobe_o
);
   logic [17:0] left_reg;

   assign strobe_o = (left_reg != 18'h0_0000);

   // stop beats start: a pulse never runs into row readout
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         left_reg <= 18'h0_0000;
      end else if (stop_i) begin
         left_reg <= 18'h0_0000;
      end else if (start_i) begin
         left_reg <= {count_i, {`DPF_XENON_UNIT_BITS{1'b0}}};
      end else if (pix_en_i && strobe_o) begin
         left_reg <= left_reg - 18'h0_0001;
      end
   end
endmodule

// ### tb/dpf_ctrl_chk.sv
`timescale 1ns/1ps
module dpf_ctrl_chk #(
   parameter int unsigned ROW_PIX = 1800
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [9:0] pix_data_o,
   input wire logic line_active_o,
   input wire logic frame_active_o,
   input wire logic flash_strobe_o,
   input wire logic irq_o
);
   logic [15:0] run_reg;
   logic [15:0] gap_reg;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////
   // strobe length and line spacing, in clocks
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_reg <= 16'h0000;
         gap_reg <= 16'h0000;
      end else begin
         run_reg <= flash_strobe_o ? run_reg + 16'h0001 : 16'h0000;
         gap_reg <= $rose(line_active_o) ? 16'h0001 : gap_reg + 16'h0001;
      end
   end
   AST_ACK_NEXT: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data outside ack");
   AST_PIX_IDLE: assert property (!line_active_o |-> pix_data_o == 10'h000)
      else $error("pixel data outside line");
   AST_LINE_FRAME: assert property (line_active_o |-> frame_active_o)
      else $error("line outside frame");
   AST_FRAME_LINE: assert property (
      $rose(frame_active_o) |-> $rose(line_active_o))
      else $error("frame start without line start");
   AST_ROW_TIME: assert property (
      $rose(line_active_o) && !$rose(frame_active_o) |->
      gap_reg == 2 * ROW_PIX)
      else $error("row time changed");
   AST_STROBE_BLANK: assert property (
      frame_active_o && $past(frame_active_o) |-> !flash_strobe_o)
      else $error("strobe outside vertical blanking");
   AST_STROBE_LEN: assert property (
      $fell(flash_strobe_o) |-> run_reg[10:0] == 11'h000 || frame_active_o)
      else $error("strobe length not whole units");
   AST_RESET_OUT: assert property (
      $fell(rst_i) |-> !flash_strobe_o && !irq_o && !frame_active_o)
      else $error("outputs active after reset");
endmodule

// ### tb/dpf_host_model.sv
`timescale 1ns/1ps
module dpf_host_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [9:0] pix_data_i,
   input wire logic line_active_i,
   input wire logic frame_active_i,
   output logic [15:0] frames_o,
   output logic [5:0] lines_o,
   output logic [7:0] len_o,
   output logic [9:0] line0_o [64]
);
   logic la_reg;
   logic fa_reg;
   logic first_reg;
   logic [8:0] pos_reg;
   logic [5:0] cnt_reg;
   logic [5:0] base;
   logic [8:0] pos;
   ////////////////////////////////////////
   // pixels stand two clocks; only the first line is kept
   assign base = (frame_active_i && !fa_reg) ? 6'h00 : cnt_reg;
   assign pos = la_reg ? pos_reg : 9'h000;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         la_reg <= 1'b0;
         fa_reg <= 1'b0;
         first_reg <= 1'b0;
         pos_reg <= 9'h000;
         cnt_reg <= 6'h00;
         len_o <= 8'h00;
         lines_o <= 6'h00;
         frames_o <= 16'h0000;
      end else begin
         la_reg <= line_active_i;
         fa_reg <= frame_active_i;
         if (line_active_i) begin
            pos_reg <= pos + 9'h001;
            if (!pos[0] && (la_reg ? first_reg : base == 6'h00))
               line0_o[pos[6:1]] <= pix_data_i;
         end
         if (line_active_i && !la_reg) begin
            first_reg <= (base == 6'h00);
            cnt_reg <= base + 6'h01;
         end
         if (!line_active_i && la_reg && first_reg)
            len_o <= pos_reg[8:1];
         if (!frame_active_i && fa_reg) begin
            lines_o <= cnt_reg;
            frames_o <= frames_o + 16'h0001;
         end
      end
   end
endmodule

// ### tb/dpf_ctrl_tb_top.sv
`timescale 1ns/1ps
`include "dpf_consts.svh"
module dpf_ctrl_tb_top import dpf_pkg::*; ;
   localparam int AC = 16;
   localparam int AR = 16;
   localparam logic [9:0] RI [6] = '{`DPF_IDX_READ_MODE_A, `DPF_IDX_SHOW_CTRL,
      `DPF_IDX_FLASH_CTRL, `DPF_IDX_IRQ_ENABLE, `DPF_IDX_DARK_STATUS, 10'h100};
   localparam dpf_reg16_t RV [6] = '{16'h8490, 16'h0107, 16'h0008,
      16'h0000, 16'h0028, 16'h0000};
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [11:0] adr = 12'h000;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0000_0000;
   logic [31:0] dat_o;
   logic ack, la, fa, strobe, irq;
   logic [9:0] pix;
   logic [15:0] frames;
   logic [5:0] lines;
   logic [7:0] len;
   logic [9:0] line0 [64];
   int miscompares = 0;
   int comparisons = 0;
   dpf_reg16_t q;
   always #2.5 clk_i = ~clk_i;
   dpf_ctrl #(.ACT_COLS(AC), .ACT_ROWS(AR), .ROW_PIX(80), .VBLANK_ROWS(16))
   dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .pix_data_o(pix),
      .line_active_o(la), .frame_active_o(fa), .flash_strobe_o(strobe),
      .irq_o(irq));
   dpf_host_model host (.clk_i(clk_i), .rst_i(rst_i), .pix_data_i(pix),
      .line_active_i(la), .frame_active_i(fa), .frames_o(frames),
      .lines_o(lines), .len_o(len), .line0_o(line0));
   ////////////////////////////////////////
   task automatic close_out;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one classic cycle; returns read data in q
   task automatic bus(input logic w, input logic [9:0] i, input dpf_reg16_t d,
      input logic [3:0] s);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {i, 2'b00};
      sel <= s;
      dat <= {16'h0000, d};
      // only an ack ends this wait; a missing ack is left to the watchdog
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      q = dat_o[15:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
      chk("ack drop", 16'h0000, {15'h0000, ack});
   endtask
   task automatic wait_frames(input int k);
      logic [15:0] t;
      t = frames + 16'(k);
      repeat (30000) begin
         @(posedge clk_i);
         if (frames === t) break;
      end
      if (frames !== t) chk("frames", t, frames);
   endtask
   function automatic int ncols(input logic b, input logic w);
      return b ? 40 : (w ? 36 : 20);
   endfunction
   function automatic int rows(input logic a, input int f, input dpf_reg16_t s);
      return (a ? AR >> (f + 1) : AR) + (s[7] ? s[2:0] + 1 : 0);
   endfunction
   initial begin
      int f, nc, ld, s, k;
      logic a, bin, b, p;
      dpf_reg16_t sc;
      void'($urandom(32'h9ace));
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("strobe", 16'h0000, {15'h0000, strobe});
      foreach (RI[j]) begin
         bus(1'b0, RI[j], 16'h0000, 4'h3);
         chk("reset", RV[j], q);
      end
      bus(1'b1, `DPF_IDX_FLASH_CTRL, 16'hC708, 4'h3);
      bus(1'b0, `DPF_IDX_FLASH_CTRL, 16'h0000, 4'h3);
      chk("flash ro", 16'h0008, q);
      // low lane only; reserved bit 3 written as zero
      bus(1'b1, `DPF_IDX_SHOW_CTRL, 16'hFFA5, 4'h1);
      bus(1'b0, `DPF_IDX_SHOW_CTRL, 16'h0000, 4'h3);
      chk("lane", 16'h01A5, q);
      for (int i = 0; i < 5; i++) begin
         a = (i < 4);
         f = i & 3;
         bin = 1'($urandom);
         b = a & bin;
         sc = 16'($urandom) & 16'h07F7;
         s = $urandom_range(7 - sc[2:0], 0);
         sc[6:4] = 3'(s);
         bus(1'b1, `DPF_IDX_CTX_SEL, a ? 16'h0000 : 16'h0008, 4'h3);
         bus(1'b1, `DPF_IDX_READ_MODE_A,
            16'h0490 | (16'(bin) << 15) | (16'(f) << 2), 4'h3);
         bus(1'b1, `DPF_IDX_SHOW_CTRL, sc, 4'h3);
         wait_frames(2);
         nc = ncols(b, sc[10]);
         ld = sc[9] ? nc + 2 : 0;
         chk("lines", 16'(rows(a, f, sc)), {10'h000, lines});
         chk("len", 16'(ld + AC), {8'h00, len});
         bus(1'b0, `DPF_IDX_DARK_STATUS, 16'h0000, 4'h3);
         chk("dstat", {4'h0, 6'(ld), sc[8] ? 6'(nc) : 6'h00},
            q);
         if (sc[9]) begin
            k = b ? 0 : 4;
            chk("dark0", 16'(k), {6'h00, line0[0]});
            chk("darkn", 16'(k + nc - 1), {6'h00, line0[nc - 1]});
            chk("gap", 16'h0000, {6'h00, line0[nc] | line0[nc + 1]});
         end
         if (sc[7]) chk("drow", 16'(4 + s), {6'h00, line0[ld]});
      end
      // flash: delay two frames, one unit
      bus(1'b1, `DPF_IDX_IRQ_ENABLE, 16'h0006, 4'h3);
      bus(1'b1, `DPF_IDX_FLASH_CTRL, 16'h3001, 4'h3);
      k = 0;
      p = fa;
      repeat (30000) begin
         @(posedge clk_i);
         if (p && !fa) k++;
         p = fa;
         if (strobe === 1'b1) break;
      end
      chk("delay", 16'h0003, 16'(k));
      repeat (20) @(posedge clk_i);
      bus(1'b0, `DPF_IDX_FLASH_CTRL, 16'h0000, 4'h3);
      chk("flash on", 16'hF001, q);
      chk("irq on", 16'h0001, {15'h0000, irq});
      repeat (3000) begin
         @(posedge clk_i);
         if (strobe === 1'b0) break;
      end
      bus(1'b0, `DPF_IDX_FLASH_CTRL, 16'h0000, 4'h3);
      chk("flash off", 16'h7001, q);
      bus(1'b0, `DPF_IDX_IRQ_STATUS, 16'h0000, 4'h3);
      chk("status", 16'h0007, q);
      bus(1'b1, `DPF_IDX_FLASH_CTRL, 16'h0000, 4'h3);
      bus(1'b1, `DPF_IDX_IRQ_CLEAR, 16'h0007, 4'h1);
      bus(1'b0, `DPF_IDX_IRQ_STATUS, 16'h0000, 4'h3);
      chk("cleared", 16'h0000, q);
      chk("irq off", 16'h0000, {15'h0000, irq});
      wait_frames(1);
      bus(1'b0, `DPF_IDX_IRQ_STATUS, 16'h0000, 4'h3);
      chk("masked", 16'h0001, {q[15:1], irq ^ q[0]});
      bus(1'b1, `DPF_IDX_IRQ_ENABLE, 16'h0001, 4'h3);
      repeat (2) @(posedge clk_i);
      chk("irq en", 16'h0001, {15'h0000, irq});
      close_out();
   end
   // whole run is well under this; a hang ends here
   initial begin
      repeat (90000) @(posedge clk_i);
      miscompares++;
      close_out();
   end
endmodule
bind dpf_ctrl dpf_ctrl_chk #(.ROW_PIX(ROW_PIX)) u_chk (.clk_i(clk_i),
   .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pix_data_o(pix_data_o),
   .line_active_o(line_active_o), .frame_active_o(frame_active_o),
   .flash_strobe_o(flash_strobe_o), .irq_o(irq_o));
